// File: tpc_pkg.sv
// Package: shared constants and carriers of the timer/PWM block
package tpc_pkg;

    // ****************************************************************
    // Widths and encodings
    // ****************************************************************
    localparam int CNT_W = 16;
    localparam int NCH   = 2;

    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;

    // Counter clock source select
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_BUS = 2'h1;
    localparam logic [1:0] CLK_FIX = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;

    // Channel mode select
    localparam logic [1:0] MODE_CAP = 2'h0;
    localparam logic [1:0] MODE_CMP = 2'h1;

    // Edge/level select codes
    localparam logic [1:0] ELS_NONE = 2'h0;
    localparam logic [1:0] ELS_A    = 2'h1;
    localparam logic [1:0] ELS_B    = 2'h2;
    localparam logic [1:0] ELS_AB   = 2'h3;

    localparam logic [2:0] PS_MAX = 3'h7;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] els;
    } tpc_chcfg_s;

    typedef struct packed {
        logic       dec;
        logic       zero;
        logic       top;
    } tpc_cnt_s;

endpackage

// File: tpc_sync.sv
// Module: two-stage level synchroniser
`timescale 1ns/100ps
module tpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            q_o  <= '0;
        end else begin
            s1_q <= d_i;
            q_o  <= s1_q;
        end
    end
endmodule

// File: tpc_prescale.sv
// Module: counter tick generation with source select and prescaler
`timescale 1ns/100ps
module tpc_prescale (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] src_i,
    input  wire logic [2:0] ps_i,
    input  wire logic       fix_s_i,
    input  wire logic       ext_s_i,
    input  wire logic       halt_i,
    output logic            tick_o
);
    logic       fix_d_q;
    logic       ext_d_q;
    logic       raw;
    logic [7:0] div_q;
    logic [7:0] div_d;

    // Edge detection on already synchronised sources
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fix_d_q <= 1'b0;
            ext_d_q <= 1'b0;
        end else begin
            fix_d_q <= fix_s_i;
            ext_d_q <= ext_s_i;
        end
    end

    always_comb begin
        unique case (src_i)
            tpc_pkg::CLK_OFF: raw = 1'b0;
            tpc_pkg::CLK_BUS: raw = 1'b1;
            tpc_pkg::CLK_FIX: raw = fix_s_i & ~fix_d_q;
            tpc_pkg::CLK_EXT: raw = ext_s_i & ~ext_d_q;
        endcase
        raw   = raw & ~halt_i;
        div_d = div_q + 8'h01;
    end

    // Divide by 2**ps
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q  <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (raw) begin
                div_q <= div_d;
                if ((div_q & ((8'h01 << ps_i) - 8'h01)) ==
                    ((8'h01 << ps_i) - 8'h01)) begin
                    tick_o <= 1'b1;
                end
            end
        end
    end

    a_halt_no_tick: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        halt_i |=> !tick_o)
        else $error("tick while halted");
    a_div_one: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (src_i == tpc_pkg::CLK_BUS && ps_i == 3'h0 && !halt_i)
        |=> tick_o)
        else $error("divide by one missed a tick");
endmodule

// File: tpc_top.sv
// Module: 16-bit timer with capture, compare and PWM channels
//
// Overview of operation
// - Prescaler divides the selected clock by 1 to 128.
// - Counter clock is prescaled bus, fixed system clock or external pin.
// - Fixed system clock is synchronised to the bus clock before use.
// - 16-bit counter: free-running or modulo, up or up/down.
// - Modulo of zero or all ones gives full free-running range.
// - Reading count is harmless; a count write strobe clears the counter.
// - Capture copies counter on selected pin edge and sets channel flag.
// - Compare match sets flag and clears, sets, toggles or ignores pin.
// - Edge PWM period is modulo plus one; value sets duty; polarity set.
// - Edge PWM sets channel flag at duty transition, overflow flag at period end.
// - Edge PWM leading edges align at counter zero for all channels.
// - One bit turns all channels to center PWM, disabling other modes.
// - Center PWM counts up to modulo then down; period twice modulo.
// - Center PWM: active on down match, inactive on up match.
// - Background debug suspends counting until normal mode returns.
// - Wait mode leaves the timer running normally.
// - Stop mode halts everything since clocks stop.
// - One flag per channel plus one overflow flag.
// - Position select bit routes each channel to default or alternate pin.
// - External clock pin may feed this timer and the modulo timer.
`timescale 1ns/100ps
module tpc_top #(
    parameter int NCH = tpc_pkg::NCH
) (
    // Clock and reset
    input  wire logic                   CLOCK_I,
    input  wire logic                   RSTN_I,
    // Mode inputs
    input  wire logic                   DEBUG_MODE_I,
    input  wire logic                   WAIT_MODE_I,
    // Timer configuration
    input  wire logic [1:0]             CLK_SRC_I,
    input  wire logic [2:0]             PRESCALE_I,
    input  wire logic                   CENTER_PWM_I,
    input  wire logic [15:0]            MODULO_I,
    input  wire logic                   COUNT_WR_I,
    input  wire logic                   OVF_CLR_I,
    // Clock pins
    input  wire logic                   FIXED_CLK_I,
    input  wire logic                   EXT_CLK_PIN_I,
    // Channel configuration
    input  tpc_pkg::tpc_chcfg_s [NCH-1:0] CH_CFG_I,
    input  wire logic [NCH-1:0][15:0]   CH_VALUE_I,
    input  wire logic [NCH-1:0]         CH_VALUE_WR_I,
    input  wire logic [NCH-1:0]         CH_FLAG_CLR_I,
    input  wire logic [NCH-1:0]         POS_SEL_I,
    // Channel pins, default and alternate position
    input  wire logic [NCH-1:0]         PIN_DEF_I,
    input  wire logic [NCH-1:0]         PIN_ALT_I,
    output logic      [NCH-1:0]         PIN_DEF_O,
    output logic      [NCH-1:0]         PIN_DEF_OE_O,
    output logic      [NCH-1:0]         PIN_ALT_O,
    output logic      [NCH-1:0]         PIN_ALT_OE_O,
    // Status
    output logic      [15:0]            COUNT_O,
    output logic                        COUNT_DOWN_O,
    output logic                        OVF_FLAG_O,
    output logic      [NCH-1:0]         CH_FLAG_O,
    output logic      [NCH-1:0][15:0]   CH_CAPTURE_O
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    logic [NCH-1:0] def_s;
    logic [NCH-1:0] alt_s;
    logic [NCH-1:0] pin_s;
    logic [NCH-1:0] pin_s_q;
    logic           fix_s;
    logic           ext_s;
    logic           dbg_s;

    // Pins cross in two flops; pulses under one clock may be lost
    tpc_sync #(.W(2 * NCH + 3)) u_sync (
        .clk_i   (CLOCK_I),
        .rst_n_i (rst_n),
        .d_i     ({PIN_ALT_I, PIN_DEF_I, FIXED_CLK_I, EXT_CLK_PIN_I,
                   DEBUG_MODE_I}),
        .q_o     ({alt_s, def_s, fix_s, ext_s, dbg_s})
    );

    // Moving a channel may look like an edge if the two pins differ
    assign pin_s = (POS_SEL_I & alt_s) | (~POS_SEL_I & def_s);

    // ****************************************************************
    // Counter tick
    // ****************************************************************
    logic tick;

    // Ext pin is input only here, so another timer may share it
    tpc_prescale u_pre (
        .clk_i   (CLOCK_I),
        .rst_n_i (rst_n),
        .src_i   (CLK_SRC_I),
        .ps_i    (PRESCALE_I),
        .fix_s_i (fix_s),
        .ext_s_i (ext_s),
        .halt_i  (dbg_s),
        .tick_o  (tick)
    );

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        dir_q;
    logic        dir_d;
    logic        free_run;
    logic [15:0] top;
    logic        wrap;

    // Wait mode is not gated: counting goes on as normal
    assign free_run = (MODULO_I == tpc_pkg::CNT_ZERO) ||
                      (MODULO_I == tpc_pkg::CNT_FULL);
    assign top      = free_run ? tpc_pkg::CNT_FULL : MODULO_I;

    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        wrap  = 1'b0;
        if (CENTER_PWM_I && !free_run) begin
            if (!dir_q && cnt_q >= top) begin
                dir_d = 1'b1;
                cnt_d = cnt_q - 16'h0001;
            end else if (dir_q && cnt_q == tpc_pkg::CNT_ZERO) begin
                dir_d = 1'b0;
                cnt_d = 16'h0001;
                wrap  = 1'b1;
            end else begin
                cnt_d = dir_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end
        end else begin
            dir_d = 1'b0;
            if (cnt_q >= top) begin
                cnt_d = tpc_pkg::CNT_ZERO;
                wrap  = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // Stop mode needs no logic: with no clock nothing moves
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= tpc_pkg::CNT_ZERO;
            dir_q <= 1'b0;
        end else if (COUNT_WR_I) begin
            cnt_q <= tpc_pkg::CNT_ZERO;
            dir_q <= 1'b0;
        end else if (tick) begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // Set beats clear
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            OVF_FLAG_O <= 1'b0;
        end else if (tick && wrap && !COUNT_WR_I) begin
            OVF_FLAG_O <= 1'b1;
        end else if (OVF_CLR_I) begin
            OVF_FLAG_O <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            COUNT_O      <= tpc_pkg::CNT_ZERO;
            COUNT_DOWN_O <= 1'b0;
        end else begin
            COUNT_O      <= cnt_q;
            COUNT_DOWN_O <= dir_q;
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    logic [NCH-1:0] out_q;
    logic [NCH-1:0] drive_q;

    for (genvar n = 0; n < NCH; n++) begin : g_ch
        logic [1:0]  md;
        logic [1:0]  els;
        logic        match;
        logic        rise;
        logic        fall;
        logic        hit;
        logic        out_d;
        logic        en;
        logic        capt;
        logic        lead;

        assign md    = CH_CFG_I[n].mode;
        assign els   = CH_CFG_I[n].els;
        assign en    = (els != tpc_pkg::ELS_NONE);
        assign match = tick && (cnt_q == CH_VALUE_I[n]);
        // Edge PWM acts on the coming count, so duty equals the value
        assign lead  = tick && !COUNT_WR_I &&
                       (cnt_d == CH_VALUE_I[n]);
        assign rise  = pin_s[n] & ~pin_s_q[n];
        assign fall  = ~pin_s[n] & pin_s_q[n];
        assign capt  = !CENTER_PWM_I && en && md == tpc_pkg::MODE_CAP &&
                       ((rise && els[0]) || (fall && els[1]));

        always_comb begin
            out_d = out_q[n];
            hit   = 1'b0;
            if (CENTER_PWM_I) begin
                if (match && dir_q) begin
                    out_d = ~els[0];
                    hit   = 1'b1;
                end else if (match && !dir_q) begin
                    out_d = els[0];
                    hit   = 1'b1;
                end
            end else if (md[1]) begin
                if (tick && wrap) begin
                    out_d = ~els[0];
                end else if (lead) begin
                    out_d = els[0];
                    hit   = 1'b1;
                end
            end else if (md == tpc_pkg::MODE_CMP && match) begin
                hit = 1'b1;
                unique case (els)
                    tpc_pkg::ELS_NONE: out_d = out_q[n];
                    tpc_pkg::ELS_A:    out_d = ~out_q[n];
                    tpc_pkg::ELS_B:    out_d = 1'b0;
                    tpc_pkg::ELS_AB:   out_d = 1'b1;
                endcase
            end else begin
                hit = capt;
            end
        end

        always_ff @(posedge CLOCK_I or negedge rst_n) begin
            if (!rst_n) begin
                pin_s_q[n] <= 1'b0;
                out_q[n]   <= 1'b0;
                drive_q[n] <= 1'b0;
            end else begin
                pin_s_q[n] <= pin_s[n];
                out_q[n]   <= out_d;
                drive_q[n] <= en && CLK_SRC_I != tpc_pkg::CLK_OFF &&
                              (CENTER_PWM_I || md != tpc_pkg::MODE_CAP);
            end
        end

        always_ff @(posedge CLOCK_I or negedge rst_n) begin
            if (!rst_n) begin
                CH_FLAG_O[n] <= 1'b0;
            end else if (hit) begin
                CH_FLAG_O[n] <= 1'b1;
            end else if (CH_FLAG_CLR_I[n]) begin
                CH_FLAG_O[n] <= 1'b0;
            end
        end

        always_ff @(posedge CLOCK_I or negedge rst_n) begin
            if (!rst_n) begin
                CH_CAPTURE_O[n] <= tpc_pkg::CNT_ZERO;
            end else if (capt) begin
                CH_CAPTURE_O[n] <= cnt_q;
            end else if (CH_VALUE_WR_I[n]) begin
                CH_CAPTURE_O[n] <= CH_VALUE_I[n];
            end
        end

        always_ff @(posedge CLOCK_I or negedge rst_n) begin
            if (!rst_n) begin
                PIN_DEF_O[n]    <= 1'b0;
                PIN_ALT_O[n]    <= 1'b0;
                PIN_DEF_OE_O[n] <= 1'b0;
                PIN_ALT_OE_O[n] <= 1'b0;
            end else begin
                PIN_DEF_O[n]    <= out_q[n];
                PIN_ALT_O[n]    <= out_q[n];
                PIN_DEF_OE_O[n] <= drive_q[n] & ~POS_SEL_I[n];
                PIN_ALT_OE_O[n] <= drive_q[n] & POS_SEL_I[n];
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_count_write: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        COUNT_WR_I |=> cnt_q == tpc_pkg::CNT_ZERO)
        else $error("count write did not clear counter");
    a_modulo_wrap: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (tick && !COUNT_WR_I && !CENTER_PWM_I && cnt_q == top)
        |=> cnt_q == tpc_pkg::CNT_ZERO)
        else $error("counter did not wrap at modulo");
    a_free_range: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (tick && !COUNT_WR_I && free_run && cnt_q == 16'hFFFE)
        |=> cnt_q == tpc_pkg::CNT_FULL)
        else $error("free running counter stopped short");
    a_debug_hold: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (dbg_s && !COUNT_WR_I) [*2] |=> $stable(cnt_q))
        else $error("counter moved in debug");
    a_ovf_set: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (tick && wrap && !COUNT_WR_I) |=> OVF_FLAG_O)
        else $error("overflow flag not set");
    a_center_down: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (CENTER_PWM_I && !free_run && tick && !COUNT_WR_I && !dir_q &&
         cnt_q == top) |=> dir_q)
        else $error("center count did not turn down");
    a_capture_val: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        g_ch[0].capt |=> CH_CAPTURE_O[0] == $past(cnt_q) && CH_FLAG_O[0])
        else $error("capture value or flag wrong");
    a_epwm_start: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        (!CENTER_PWM_I && CH_CFG_I[0].mode[1] && tick && wrap)
        |=> out_q[0] == ~$past(CH_CFG_I[0].els[0]))
        else $error("pwm period start level wrong");
    a_oe_pos: assert property (
        @(posedge CLOCK_I) disable iff (!rst_n)
        !(PIN_DEF_OE_O[0] && PIN_ALT_OE_O[0]))
        else $error("both pin positions driven");

    c_capture: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        g_ch[0].capt);
    c_ovf: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        tick && wrap);
    c_center: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        CENTER_PWM_I && g_ch[0].hit);
endmodule

// File: tpc_pins_model.sv
// Pin-side partner model: channel pin levels and counter clock sources
`timescale 1ns/100ps
module tpc_pins_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Test commands: [1:0] default pins, [3:2] alternate pins
    input  wire logic [3:0] lvl_i,
    input  wire logic       ext_run_i,
    input  wire logic       fix_run_i,
    // Design pin drivers
    input  wire logic [1:0] def_o_i,
    input  wire logic [1:0] def_oe_i,
    input  wire logic [1:0] alt_o_i,
    input  wire logic [1:0] alt_oe_i,
    // Pin levels and clocks seen by the design
    output logic      [1:0] pin_def_o,
    output logic      [1:0] pin_alt_o,
    output logic            ext_clk_o,
    output logic            fix_clk_o
);
    logic [2:0] div_q;

    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // Design wins where it drives, else the outside level
    assign pin_def_o = (def_oe_i & def_o_i) | (~def_oe_i & lvl_i[1:0]);
    assign pin_alt_o = (alt_oe_i & alt_o_i) | (~alt_oe_i & lvl_i[3:2]);

    // ****************************************************************
    // Clock sources
    // ****************************************************************
    // One eighth of bus rate, safely under the quarter limit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q     <= 3'h0;
            ext_clk_o <= 1'b0;
            fix_clk_o <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            if (div_q[1:0] == 2'h3) begin
                // Clocks stand still while not requested
                ext_clk_o <= ext_run_i ? ~ext_clk_o : ext_clk_o;
                fix_clk_o <= fix_run_i ? ~fix_clk_o : fix_clk_o;
            end
        end
    end
endmodule

// File: tpc_top_tb_top.sv
// Testbench: self-checking sequences for the timer/PWM block
`timescale 1ns/100ps
module tpc_top_tb_top;
    logic clk = 1'b0, rstn = 1'b0, dbg = 1'b0, wt = 1'b0, center_aligned_pwm = 1'b0;
    logic [1:0] src = 2'h0, pos = 2'h0, vwr = 2'h0, fclr = 2'h0;
    logic [2:0] ps = 3'h0;
    logic [15:0] md = 16'h0000, a, b, d, c;
    logic cwr = 1'b0, oclr = 1'b0, ext_run = 1'b0, fix_run = 1'b0;
    logic [3:0] lvl = 4'h0;
    tpc_pkg::tpc_chcfg_s [1:0] cfg = '0;
    logic [1:0][15:0] val = '0, cap;
    logic [1:0] pd_i, pa_i, pd_o, pd_oe, pa_o, pa_oe, cflag;
    logic [15:0] cnt, mx, o0, o1, mis;
    logic dn, ovf, ext_clk, fix_clk, sp;
    int bad_count = 0, n_tests = 0, cycles = 0;

    always #4 clk = ~clk;

    tpc_top tpc_top_i (
        .CLOCK_I(clk), .RSTN_I(rstn), .DEBUG_MODE_I(dbg),
        .WAIT_MODE_I(wt), .CLK_SRC_I(src), .PRESCALE_I(ps),
        .CENTER_PWM_I(center_aligned_pwm), .MODULO_I(md), .COUNT_WR_I(cwr),
        .OVF_CLR_I(oclr), .FIXED_CLK_I(fix_clk), .EXT_CLK_PIN_I(ext_clk),
        .CH_CFG_I(cfg), .CH_VALUE_I(val), .CH_VALUE_WR_I(vwr),
        .CH_FLAG_CLR_I(fclr), .POS_SEL_I(pos), .PIN_DEF_I(pd_i),
        .PIN_ALT_I(pa_i), .PIN_DEF_O(pd_o), .PIN_DEF_OE_O(pd_oe),
        .PIN_ALT_O(pa_o), .PIN_ALT_OE_O(pa_oe), .COUNT_O(cnt),
        .COUNT_DOWN_O(dn), .OVF_FLAG_O(ovf), .CH_FLAG_O(cflag),
        .CH_CAPTURE_O(cap)
    );

    tpc_pins_model tpc_pins_model_i (
        .clk_i(clk), .rst_n_i(rstn), .lvl_i(lvl), .ext_run_i(ext_run),
        .fix_run_i(fix_run), .def_o_i(pd_o), .def_oe_i(pd_oe),
        .alt_o_i(pa_o), .alt_oe_i(pa_oe), .pin_def_o(pd_i),
        .pin_alt_o(pa_i), .ext_clk_o(ext_clk), .fix_clk_o(fix_clk)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Inputs change 1 ns after the edge, outputs settled by then
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic span(input int n, output logic [15:0] dd);
        logic [15:0] s;
        s = cnt;
        cyc(n);
        dd = cnt - s;
    endtask

    // Ones per channel, misaligned rises, peak count, down seen
    task automatic pwm(input int n);
        logic [1:0] pv;
        o0 = '0; o1 = '0; mis = '0; mx = '0; sp = 1'b0; pv = pd_o;
        repeat (n) begin
            cyc(1);
            o0 += 16'(pd_o[0]);
            o1 += 16'(pd_o[1]);
            if ((pd_o[0] & ~pv[0]) != (pd_o[1] & ~pv[1])) mis += 16'h0001;
            if (cnt > mx) mx = cnt;
            sp |= dn;
            pv = pd_o;
        end
    endtask

    task automatic pulse_clr;
        fclr = 2'h3; oclr = 1'b1; cyc(1);
        fclr = 2'h0; oclr = 1'b0; cyc(2);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_of_test;
        end
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        logic [15:0] cmp_exp [3];
        logic [1:0]  cmp_els [3];
        cmp_els = '{tpc_pkg::ELS_AB, tpc_pkg::ELS_B, tpc_pkg::ELS_A};
        cmp_exp = '{16'h0001, 16'h0000, 16'h0001};
        cyc(20);
        rstn = 1'b1;
        cyc(4);
        span(20, d); check(d, 16'h0000);
        src = tpc_pkg::CLK_BUS;
        for (int i = 0; i < 8; i++) begin
            ps = 3'(i);
            cyc(300);
            span(8 << i, d); check(d, 16'h0008);
        end
        ps = 3'h0; md = 16'hFFFF;
        cyc(4); span(10, d); check(d, 16'h000A);
        cwr = 1'b1; cyc(1); cwr = 1'b0; cyc(3);
        check(16'(cnt <= 16'h0004), 16'h0001);
        dbg = 1'b1; cyc(5); span(20, d); check(d, 16'h0000);
        dbg = 1'b0; wt = 1'b1; cyc(5);
        span(20, d); check(d, 16'h0014);
        wt = 1'b0; md = 16'h0005; cyc(20);
        pwm(24); check(mx, 16'h0005);
        span(6, d); check(d, 16'h0000);
        md = 16'h0000; src = tpc_pkg::CLK_FIX; fix_run = 1'b1; cyc(30);
        span(80, d); check(16'(d >= 9 && d <= 11), 16'h0001);
        src = tpc_pkg::CLK_EXT; ext_run = 1'b1; fix_run = 1'b0; cyc(30);
        span(80, d); check(16'(d >= 9 && d <= 11), 16'h0001);
        src = tpc_pkg::CLK_BUS; ext_run = 1'b0;
        // Input capture, levels held 8 cycles for the synchroniser
        cfg[0] = '{tpc_pkg::MODE_CAP, tpc_pkg::ELS_A};
        cfg[1] = '{tpc_pkg::MODE_CAP, tpc_pkg::ELS_B};
        pos = 2'b10; cyc(5); pulse_clr;
        a = cnt; lvl[0] = 1'b1; lvl[3] = 1'b1; cyc(8); b = cnt;
        check(16'(cflag), 16'h0001);
        check(16'(cap[0] >= a && cap[0] <= b), 16'h0001);
        lvl[1] = 1'b1; cyc(8); lvl[1] = 1'b0; cyc(8);
        check(16'(cflag[1]), 16'h0000);
        a = cnt; lvl[3] = 1'b0; cyc(8); b = cnt;
        check(16'(cflag), 16'h0003);
        check(16'(cap[1] >= a && cap[1] <= b), 16'h0001);
        pulse_clr; check(16'(cflag), 16'h0000);
        lvl[0] = 1'b0; cyc(8); check(16'(cflag), 16'h0000);
        cfg[0].els = tpc_pkg::ELS_NONE; lvl[0] = 1'b1; cyc(8);
        check(16'(cflag), 16'h0000);
        // Output compare actions
        pos = 2'b00; md = 16'h0030; val[0] = 16'h0020; vwr = 2'h1;
        cfg[1] = '{tpc_pkg::MODE_CMP, tpc_pkg::ELS_NONE}; cyc(1);
        vwr = 2'h0;
        check(cap[0], 16'h0020);
        for (int i = 0; i < 3; i++) begin
            cfg[0] = '{tpc_pkg::MODE_CMP, cmp_els[i]};
            cyc(60); pulse_clr; c = 16'(pd_o[0]); cyc(49);
            check(16'(cflag[0]), 16'h0001);
            check(16'(pd_oe[0]), 16'h0001);
            if (i == 2) check(16'(pd_o[0]), c ^ 16'h0001);
            else check(16'(pd_o[0]), cmp_exp[i]);
        end
        // Edge-aligned PWM, both channels on one period
        md = 16'h0009; val[0] = 16'h0004; val[1] = 16'h0007;
        cfg[0] = '{2'h2, tpc_pkg::ELS_B};
        cfg[1] = '{2'h2, tpc_pkg::ELS_B};
        cyc(30); pwm(20);
        check(o0, 16'h0008);
        check(o1, 16'h000E);
        check(mis, 16'h0000);
        pulse_clr; cyc(12);
        check(16'(ovf), 16'h0001);
        check(16'(cflag), 16'h0003);
        cfg[0].els = tpc_pkg::ELS_A; cyc(20); pwm(10);
        check(o0, 16'h0006);
        // Center PWM overrides the capture mode set on channel 0
        center_aligned_pwm = 1'b1; md = 16'h0008; val[0] = 16'h0003;
        cfg[0] = '{tpc_pkg::MODE_CAP, tpc_pkg::ELS_B};
        cyc(40); pulse_clr; pwm(16);
        check(o0, 16'h0006);
        check(mx, 16'h0008);
        check(16'(sp), 16'h0001);
        check(16'(ovf), 16'h0001);
        // Alternate position carries the same waveform
        pos = 2'b11; cyc(3);
        check(16'(pa_oe), 16'h0003);
        check(16'(pd_oe), 16'h0000);
        o1 = '0;
        repeat (16) begin
            cyc(1);
            o1 += 16'(pa_o[0]);
        end
        check(o1, 16'h0006);
        end_of_test;
    end
endmodule
